/* pkg/pps_pkg.sv */
// Constants, encodings and the sequencer state type of the parallel programming port.
// Assumes a 10 MHz reference clock; shared by the port logic only.
package pps_pkg;
  // Strobe action codes {strobe_action_1, strobe_action_0}
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD  = 2'h2;
  localparam logic [1:0] ACT_IDLE = 2'h3;
  // Byte select codes {byte_select_high, byte_select_low}
  localparam logic [1:0] BS_LOW   = 2'h0;
  localparam logic [1:0] BS_HIGH  = 2'h1;
  localparam logic [1:0] BS_EXT   = 2'h2;
  localparam logic [1:0] BS_RSV   = 2'h3;
  // Command bytes
  localparam logic [7:0] CMD_NOP      = 8'h00;
  localparam logic [7:0] CMD_ERASE    = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE  = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK  = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EE    = 8'h11;
  localparam logic [7:0] CMD_RD_SIG   = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE  = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EE    = 8'h03;
  // Entry sequence
  localparam logic [2:0] ENTRY_TOGGLES    = 3'h6;
  localparam int         CLK_PERIOD_NS    = 100;
  localparam int         ENTRY_SETTLE_NS  = 100;
  localparam int         ENTRY_SETTLE_CYC =
    (ENTRY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Page geometry
  localparam int FLASH_PAGE_WORDS = 128;
  localparam int EE_PAGE_BYTES    = 8;
  // Fuse and lock reset values, fuse bit that keeps the EEPROM
  localparam logic [7:0] FUSE_LOW_RST  = 8'h5e;
  localparam logic [7:0] FUSE_HIGH_RST = 8'h99;
  localparam logic [7:0] FUSE_EXT_RST  = 8'hf3;
  localparam logic [7:0] LOCK_RST      = 8'hff;
  localparam int         KEEP_EE_BIT   = 3;
  // Identity bytes: values are arbitrary
  localparam logic [7:0] SIG_BYTE0 = 8'h5a;
  localparam logic [7:0] SIG_BYTE1 = 8'h01;
  localparam logic [7:0] SIG_BYTE2 = 8'h02;
  localparam logic [7:0] CAL_BYTE  = 8'h80;
  // Synchroniser reset: the two active-low strobes idle high
  localparam logic [17:0] SYNC_RST = 18'h03000;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_STREAM = 4'b0010,
    ST_WAIT   = 4'b0100,
    ST_FINISH = 4'b1000
  } pps_state_t;
endpackage

/* logic/pps_sync.sv */
// Two-flop synchroniser for a vector of pin inputs.
// Assumes every bit is asynchronous to ref_clk and may be sampled independently.
module pps_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      logic meta_r;
      logic sync_r;
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_r <= RST[i];
          sync_r <= RST[i];
        end else begin
          meta_r <= async_in[i];
          sync_r <= meta_r;
        end
      end
      assign sync_out[i] = sync_r;
    end
  endgenerate
endmodule

/* logic/pps_port.sv */
// Device side of the parallel high-voltage programming port: entry detection,
// byte loads, page buffer, erase and page-write sequencing, fuse, lock and reads.
// Assumes a nonvolatile backend on ref_clk that pulses nvm_done when an op ends.

// Notes on behaviour
// [RULE1] ready_busy_n is low during erase or programming, high when ready.
// [RULE2] Data bus is input, driven only while output_enable_n is low.
// [RULE3] Load strobe acts by action code: address, data, command or nothing.
// [RULE4] Address loads pick low, high or extended byte; code 11 reserved.
// [RULE5] Data loads pick low or high data byte by byte_select_low.
// [RULE6] Fuse writes and fuse/lock reads are steered by the byte selects.
// [RULE7] Command bytes decode to erase, writes, and the four read kinds.
// [RULE8] Programmer toggles the load strobe six times while reset is low.
// [RULE9] Programmer drives entry pins to zero 100 ns before high voltage.
// [RULE10] Entry pins moving within 100 ns of high voltage blocks entry.
// [RULE11] Programmer waits 50 us after high voltage before a command.
// [RULE12] Command and address persist across operations.
// [RULE13] Address high bytes persist while only the low byte changes.
// [RULE14] Erase clears memories and locks, locks last; fuses untouched.
// [RULE15] Programmed keep-EEPROM fuse spares the EEPROM during erase.
// [RULE16] Write pulse after erase command starts erase and drops ready.
// [RULE17] Each load strobe captures the bus into the selected register.
// [RULE18] Page latch strobe with byte_select_low high buffers the data word.
// [RULE19] Flash page holds 64 or 128 words; low seven bits pick the word.
// [RULE20] EEPROM page holds 4 or 8 bytes; low three bits pick the byte.
// [RULE21] Upper low-byte address bits act as page bits for small pages.
// [RULE22] Programmer erases the chip before reprogramming memories.
// [RULE23] Programmer loads address, data and latch per word, then high byte.
// [RULE24] Write pulse with selects 00 programs the buffered page, drops ready.
// [RULE25] Loading the no-operation command ends page programming.
// [RULE26] Loads with a reserved byte select leave all registers unchanged; command loads still capture the bus into cmd_r.
module pps_port #(
  parameter int FLASH_PAGE_WORDS = pps_pkg::FLASH_PAGE_WORDS,
  parameter int EE_PAGE_BYTES    = pps_pkg::EE_PAGE_BYTES
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        reset_pin_low,
  input  wire logic        vpp_on,
  input  wire logic        load_strobe_clock,
  input  wire logic        page_latch_strobe,
  input  wire logic        program_strobe_n,
  input  wire logic        output_enable_n,
  input  wire logic        strobe_action_1,
  input  wire logic        strobe_action_0,
  input  wire logic        byte_select_high,
  input  wire logic        byte_select_low,
  input  wire logic [7:0]  data_in,
  output logic      [7:0]  data_out,
  output logic             data_oe,
  output logic             ready_busy_n,
  output logic             prog_mode,
  input  wire logic        nvm_done,
  input  wire logic [15:0] nvm_rdata,
  output logic      [23:0] nvm_rd_addr,
  output logic             nvm_erase,
  output logic             nvm_erase_eeprom,
  output logic             nvm_we,
  output logic             nvm_is_eeprom,
  output logic      [23:0] nvm_waddr,
  output logic      [15:0] nvm_wdata,
  output logic             nvm_commit,
  output logic      [23:0] nvm_page_addr,
  output logic      [7:0]  fuse_low,
  output logic      [7:0]  fuse_high,
  output logic      [7:0]  fuse_ext,
  output logic      [7:0]  lock_bits
);
  localparam int FW_IDX = $clog2(FLASH_PAGE_WORDS);
  localparam int EW_IDX = $clog2(EE_PAGE_BYTES);

  logic [17:0] pins_s;
  logic [7:0]  din_s;
  logic        bs1_s, bs2_s, xa0_s, xa1_s, oe_n_s, wr_n_s, pgl_s, xs_s, rlow_s, vpp_s;
  logic        xs_d_r, pgl_d_r, wr_n_d_r, vpp_d_r;
  logic        xs_rise, pgl_rise, wr_fall, vpp_rise;
  logic [1:0]  act, bsel;
  logic [3:0]  entry_s;

  pps_sync #(
    .W   (18),
    .RST (pps_pkg::SYNC_RST)
  ) u_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in ({vpp_on, reset_pin_low, load_strobe_clock, page_latch_strobe,
                program_strobe_n, output_enable_n, strobe_action_1, strobe_action_0,
                byte_select_high, byte_select_low, data_in}),
    .sync_out (pins_s)
  );

  assign din_s  = pins_s[7:0];
  assign bs1_s  = pins_s[8];
  assign bs2_s  = pins_s[9];
  assign xa0_s  = pins_s[10];
  assign xa1_s  = pins_s[11];
  assign oe_n_s = pins_s[12];
  assign wr_n_s = pins_s[13];
  assign pgl_s  = pins_s[14];
  assign xs_s   = pins_s[15];
  assign rlow_s = pins_s[16];
  assign vpp_s  = pins_s[17];
  assign act     = {xa1_s, xa0_s};
  assign bsel    = {bs2_s, bs1_s};
  assign entry_s = {pgl_s, xa1_s, xa0_s, bs1_s};

  // Edge detection on the synchronised strobes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      xs_d_r   <= 1'b0;
      pgl_d_r  <= 1'b0;
      wr_n_d_r <= 1'b1;
      vpp_d_r  <= 1'b0;
    end else begin
      xs_d_r   <= xs_s;
      pgl_d_r  <= pgl_s;
      wr_n_d_r <= wr_n_s;
      vpp_d_r  <= vpp_s;
    end
  end
  assign xs_rise  = xs_s & ~xs_d_r;
  assign pgl_rise = pgl_s & ~pgl_d_r;
  assign wr_fall  = ~wr_n_s & wr_n_d_r;
  assign vpp_rise = vpp_s & ~vpp_d_r;

  // Entry into programming mode
  logic [2:0] tog_r;
  logic [3:0] settle_r;
  logic       settling_r;
  logic       prog_mode_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tog_r       <= 3'h0;
      settle_r    <= 4'h0;
      settling_r  <= 1'b0;
      prog_mode_r <= 1'b0;
    end else if (!vpp_s) begin
      prog_mode_r <= 1'b0;
      settling_r  <= 1'b0;
      if (!rlow_s) begin
        tog_r <= 3'h0;
      end else if (xs_rise && tog_r != pps_pkg::ENTRY_TOGGLES) begin
        tog_r <= tog_r + 3'h1;
      end
    end else if (vpp_rise) begin
      settling_r <= (tog_r == pps_pkg::ENTRY_TOGGLES) && (entry_s == 4'h0);
      settle_r   <= 4'(pps_pkg::ENTRY_SETTLE_CYC);
      tog_r      <= 3'h0;
    end else if (settling_r) begin
      if (entry_s != 4'h0) begin
        settling_r <= 1'b0; // RULE10
      end else if (settle_r == 4'h1) begin
        settling_r  <= 1'b0;
        prog_mode_r <= 1'b1;
      end else begin
        settle_r <= settle_r - 4'h1;
      end
    end
  end

  // Load registers
  pps_pkg::pps_state_t st_r, st_nxt;
  logic [7:0]  cmd_r;
  logic [23:0] addr_r;
  logic [7:0]  dlo_r, dhi_r;
  logic        load_ok;

  assign load_ok = prog_mode_r && xs_rise && (st_r == pps_pkg::ST_IDLE);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_r  <= pps_pkg::CMD_NOP;
      addr_r <= 24'h000000;
      dlo_r  <= 8'hff;
      dhi_r  <= 8'hff;
    end else if (!prog_mode_r) begin
      cmd_r <= pps_pkg::CMD_NOP;
    end else if (load_ok) begin // RULE17
      unique case (act) // RULE3
        pps_pkg::ACT_ADDR: begin
          unique case (bsel) // RULE4
            pps_pkg::BS_LOW:  addr_r[7:0]   <= din_s; // RULE13
            pps_pkg::BS_HIGH: addr_r[15:8]  <= din_s;
            pps_pkg::BS_EXT:  addr_r[23:16] <= din_s;
            pps_pkg::BS_RSV:  addr_r        <= addr_r; // RULE26
          endcase
        end
        pps_pkg::ACT_DATA: begin
          if (!bs2_s) begin // RULE26
            if (bs1_s) begin // RULE5
              dhi_r <= din_s;
            end else begin
              dlo_r <= din_s;
            end
          end
        end
        pps_pkg::ACT_CMD:  cmd_r <= din_s; // RULE25
        pps_pkg::ACT_IDLE: cmd_r <= cmd_r;
      endcase
    end
  end

  // Page buffer
  logic [15:0]       page_mem [FLASH_PAGE_WORDS];
  logic [FW_IDX-1:0] wr_idx;
  logic              is_ee_cmd;

  assign is_ee_cmd = (cmd_r == pps_pkg::CMD_WR_EE);
  assign wr_idx    = is_ee_cmd ? FW_IDX'(addr_r[EW_IDX-1:0]) : addr_r[FW_IDX-1:0]; // RULE19 RULE20

  always_ff @(posedge ref_clk) begin
    if (prog_mode_r && pgl_rise && bs1_s && (st_r == pps_pkg::ST_IDLE)) begin // RULE18
      page_mem[wr_idx] <= {dhi_r, dlo_r};
    end
  end

  // Operation sequencer
  logic [7:0]        op_cmd_r;
  logic [1:0]        op_bs_r;
  logic [FW_IDX-1:0] cnt_r;
  logic [FW_IDX-1:0] cnt_last;
  logic              op_ee_r;
  logic [23:0]       page_base_r;

  assign cnt_last = op_ee_r ? FW_IDX'(EE_PAGE_BYTES - 1) : FW_IDX'(FLASH_PAGE_WORDS - 1);

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      pps_pkg::ST_IDLE: begin
        if (prog_mode_r && wr_fall) begin
          unique case (cmd_r) // RULE7
            pps_pkg::CMD_ERASE: st_nxt = pps_pkg::ST_WAIT; // RULE16
            pps_pkg::CMD_WR_FLASH,
            pps_pkg::CMD_WR_EE: begin
              if (bsel == pps_pkg::BS_LOW) begin // RULE24
                st_nxt = pps_pkg::ST_STREAM;
              end
            end
            pps_pkg::CMD_WR_FUSE,
            pps_pkg::CMD_WR_LOCK: st_nxt = pps_pkg::ST_FINISH;
            default: st_nxt = pps_pkg::ST_IDLE;
          endcase
        end
      end
      pps_pkg::ST_STREAM: begin
        if (cnt_r == cnt_last) begin
          st_nxt = pps_pkg::ST_WAIT;
        end
      end
      pps_pkg::ST_WAIT: begin
        if (nvm_done) begin
          st_nxt = pps_pkg::ST_FINISH;
        end
      end
      pps_pkg::ST_FINISH: st_nxt = pps_pkg::ST_IDLE;
      default: st_nxt = pps_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r         <= pps_pkg::ST_IDLE;
      ready_busy_n <= 1'b1;
    end else begin
      st_r         <= st_nxt;
      ready_busy_n <= (st_nxt == pps_pkg::ST_IDLE); // RULE1
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_cmd_r    <= pps_pkg::CMD_NOP;
      op_bs_r     <= 2'h0;
      op_ee_r     <= 1'b0;
      cnt_r       <= '0;
      page_base_r <= 24'h000000;
    end else if (st_r == pps_pkg::ST_IDLE) begin
      op_cmd_r <= cmd_r; // RULE12
      op_bs_r  <= bsel;
      op_ee_r  <= is_ee_cmd;
      cnt_r    <= '0;
      if (is_ee_cmd) begin
        page_base_r <= addr_r & ~24'(EE_PAGE_BYTES - 1);
      end else begin
        page_base_r <= addr_r & ~24'(FLASH_PAGE_WORDS - 1); // RULE21
      end
    end else if (st_r == pps_pkg::ST_STREAM) begin
      cnt_r <= cnt_r + FW_IDX'(1);
    end
  end

  // Backend requests
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      nvm_erase        <= 1'b0;
      nvm_erase_eeprom <= 1'b0;
      nvm_we           <= 1'b0;
      nvm_is_eeprom    <= 1'b0;
      nvm_waddr        <= 24'h000000;
      nvm_wdata        <= 16'hffff;
      nvm_commit       <= 1'b0;
      nvm_page_addr    <= 24'h000000;
    end else begin
      nvm_erase        <= (st_r == pps_pkg::ST_IDLE) && (st_nxt == pps_pkg::ST_WAIT); // RULE14
      nvm_erase_eeprom <= fuse_high[pps_pkg::KEEP_EE_BIT]; // RULE15
      nvm_we           <= (st_r == pps_pkg::ST_STREAM);
      nvm_is_eeprom    <= op_ee_r;
      nvm_waddr        <= page_base_r | 24'(cnt_r);
      nvm_wdata        <= page_mem[cnt_r];
      nvm_commit       <= (st_r == pps_pkg::ST_STREAM) && (cnt_r == cnt_last);
      nvm_page_addr    <= page_base_r;
    end
  end

  // Fuse and lock bytes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fuse_low  <= pps_pkg::FUSE_LOW_RST;
      fuse_high <= pps_pkg::FUSE_HIGH_RST;
      fuse_ext  <= pps_pkg::FUSE_EXT_RST;
      lock_bits <= pps_pkg::LOCK_RST;
    end else if (st_r == pps_pkg::ST_FINISH) begin
      if (op_cmd_r == pps_pkg::CMD_ERASE) begin
        lock_bits <= pps_pkg::LOCK_RST; // RULE14
      end else if (op_cmd_r == pps_pkg::CMD_WR_LOCK) begin
        lock_bits <= lock_bits & dlo_r;
      end else if (op_cmd_r == pps_pkg::CMD_WR_FUSE) begin
        unique case (op_bs_r) // RULE6
          pps_pkg::BS_LOW:  fuse_low  <= dlo_r;
          pps_pkg::BS_HIGH: fuse_high <= dlo_r;
          pps_pkg::BS_EXT:  fuse_ext  <= dlo_r;
          pps_pkg::BS_RSV:  fuse_ext  <= fuse_ext;
        endcase
      end
    end
  end

  // Read path
  logic [7:0] rd_byte;

  always_comb begin
    rd_byte = 8'hff;
    unique case (cmd_r)
      pps_pkg::CMD_RD_FLASH: rd_byte = bs1_s ? nvm_rdata[15:8] : nvm_rdata[7:0];
      pps_pkg::CMD_RD_EE:    rd_byte = nvm_rdata[7:0];
      pps_pkg::CMD_RD_FUSE: begin
        unique case (bsel) // RULE6
          pps_pkg::BS_LOW:  rd_byte = fuse_low;
          pps_pkg::BS_HIGH: rd_byte = lock_bits;
          pps_pkg::BS_EXT:  rd_byte = fuse_ext;
          pps_pkg::BS_RSV:  rd_byte = fuse_high;
        endcase
      end
      pps_pkg::CMD_RD_SIG: begin
        if (bs1_s) begin
          rd_byte = pps_pkg::CAL_BYTE;
        end else if (addr_r[1:0] == 2'h0) begin
          rd_byte = pps_pkg::SIG_BYTE0;
        end else if (addr_r[1:0] == 2'h1) begin
          rd_byte = pps_pkg::SIG_BYTE1;
        end else if (addr_r[1:0] == 2'h2) begin
          rd_byte = pps_pkg::SIG_BYTE2;
        end
      end
      default: rd_byte = 8'hff;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out    <= 8'h00;
      data_oe     <= 1'b0;
      nvm_rd_addr <= 24'h000000;
      prog_mode   <= 1'b0;
    end else begin
      data_out    <= rd_byte;
      data_oe     <= prog_mode_r && !oe_n_s; // RULE2
      nvm_rd_addr <= addr_r;
      prog_mode   <= prog_mode_r;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  busy_on_erase_a: assert property ( // RULE16
    (st_r == pps_pkg::ST_IDLE) && prog_mode_r && wr_fall && (cmd_r == pps_pkg::CMD_ERASE)
    |=> !ready_busy_n [*2]) else $error("Erase start did not drop ready");
  ready_return_a: assert property ( // RULE1
    (st_r == pps_pkg::ST_FINISH) |=> ready_busy_n) else $error("Ready not restored");
  bus_drive_a: assert property ( // RULE2
    data_oe |-> $past(!oe_n_s) && prog_mode) else $error("Bus driven without enable");
  cmd_load_a: assert property ( // RULE3
    load_ok && (act == pps_pkg::ACT_CMD) |=> cmd_r == $past(din_s))
    else $error("Command not captured");
  rsv_addr_a: assert property ( // RULE26
    load_ok && (act == pps_pkg::ACT_ADDR) && (bsel == pps_pkg::BS_RSV)
    |=> $stable(addr_r)) else $error("Reserved select changed address");
  hi_keep_a: assert property ( // RULE13
    load_ok && (act == pps_pkg::ACT_ADDR) && (bsel == pps_pkg::BS_LOW)
    |=> (addr_r[23:8] == $past(addr_r[23:8])) && (addr_r[7:0] == $past(din_s)))
    else $error("Address high bytes disturbed");
  data_hi_a: assert property ( // RULE5
    load_ok && (act == pps_pkg::ACT_DATA) && (bsel == pps_pkg::BS_HIGH)
    |=> (dhi_r == $past(din_s)) && $stable(dlo_r)) else $error("Data high load wrong");
  ee_keep_a: assert property ( // RULE15
    nvm_erase |-> nvm_erase_eeprom == fuse_high[pps_pkg::KEEP_EE_BIT])
    else $error("EEPROM erase ignores keep fuse");
  lock_clear_a: assert property ( // RULE14
    (st_r == pps_pkg::ST_FINISH) && (op_cmd_r == pps_pkg::CMD_ERASE)
    |=> (lock_bits == pps_pkg::LOCK_RST) && $stable(fuse_high))
    else $error("Locks not cleared after erase");
  entry_quiet_a: assert property ( // RULE10
    $rose(prog_mode_r) |-> $past(entry_s == 4'h0) && $past(vpp_s, 2))
    else $error("Entered despite entry pin activity");
  page_start_a: assert property ( // RULE24
    (st_r == pps_pkg::ST_IDLE) && prog_mode_r && wr_fall && (bsel == pps_pkg::BS_LOW)
    && (cmd_r == pps_pkg::CMD_WR_FLASH) |=> ##1 nvm_we && !ready_busy_n)
    else $error("Page write did not start");
endmodule

/* tb/pps_prog_model.sv */
// Programmer model: drives the port's pins as a parallel programmer does.
// Assumes its tasks are called one at a time from the bench's main thread.
module pps_prog_model (
  input  wire logic       ref_clk,
  output logic            reset_pin_low,
  output logic            vpp_on,
  output logic            load_strobe_clock,
  output logic            page_latch_strobe,
  output logic            program_strobe_n,
  output logic            output_enable_n,
  output logic            strobe_action_1,
  output logic            strobe_action_0,
  output logic            byte_select_high,
  output logic            byte_select_low,
  output logic      [7:0] data_in
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    {reset_pin_low, vpp_on, load_strobe_clock, page_latch_strobe} = 4'h0;
    {program_strobe_n, output_enable_n} = 2'h3;
    {strobe_action_1, strobe_action_0, byte_select_high, byte_select_low} = 4'hf;
    data_in = 8'h00;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic enter(input logic bad);
    tick(1);
    reset_pin_low <= 1'b1;
    vpp_on        <= 1'b0;
    repeat (6) begin
      tick(4);
      load_strobe_clock <= 1'b1;
      tick(4);
      load_strobe_clock <= 1'b0;
    end
    tick(1);
    page_latch_strobe <= bad;
    {strobe_action_1, strobe_action_0, byte_select_low} <= 3'h0;
    tick(2);
    vpp_on <= 1'b1;
    tick(500);
  endtask

  task automatic leave();
    tick(1);
    vpp_on            <= 1'b0;
    reset_pin_low     <= 1'b0;
    page_latch_strobe <= 1'b0;
    tick(8);
  endtask

  task automatic load(input logic [1:0] act, input logic [1:0] bs, input logic [7:0] d);
    tick(1);
    {strobe_action_1, strobe_action_0}  <= act;
    {byte_select_high, byte_select_low} <= bs;
    data_in <= d;
    tick(2);
    load_strobe_clock <= 1'b1;
    tick(4);
    load_strobe_clock <= 1'b0;
    tick(4);
  endtask

  task automatic latch();
    tick(1);
    byte_select_low <= 1'b1;
    tick(2);
    page_latch_strobe <= 1'b1;
    tick(4);
    page_latch_strobe <= 1'b0;
    tick(4);
  endtask

  task automatic write(input logic [1:0] bs);
    tick(1);
    {byte_select_high, byte_select_low} <= bs;
    tick(2);
    program_strobe_n <= 1'b0;
    tick(4);
    program_strobe_n <= 1'b1;
    tick(4);
  endtask

  task automatic read_on(input logic [1:0] bs);
    tick(1);
    {byte_select_high, byte_select_low} <= bs;
    output_enable_n <= 1'b0;
    tick(8);
  endtask

  task automatic read_off();
    tick(1);
    output_enable_n <= 1'b1;
    tick(6);
  endtask
endmodule

/* tb/pps_port_tb.sv */
// Self-checking bench for the programming port with a programmer model.
// Assumes a backend that answers commit and erase after a fixed delay.
module pps_port_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic ref_clk, rst_n, rbl, vpp, lsc, pls, psn, oen, sa1, sa0, bsh, bsl;
  logic nvm_done, data_oe, ready_busy_n, prog_mode, nvm_erase, nvm_erase_eeprom;
  logic nvm_we, nvm_commit, nvm_is_eeprom;
  logic [7:0]  data_in, data_out, fuse_low, fuse_high, fuse_ext, lock_bits;
  logic [15:0] nvm_wdata, we_data;
  logic [23:0] nvm_rd_addr, nvm_waddr, nvm_page_addr, page_seen;
  logic [4:0]  done_cnt = 5'h00;
  logic        ee_seen = 1'b1;
  int          we_cnt = 0;
  int          mismatches = 0;
  int          checks_done = 0;
  typedef struct {logic [7:0] cmd; logic [7:0] al; logic [1:0] bs; logic [7:0] exp;} pps_row_t;
  pps_row_t rows [12] = '{
    '{8'h04, 8'h00, 2'h0, 8'h5e}, '{8'h04, 8'h00, 2'h1, 8'hff}, '{8'h04, 8'h00, 2'h2, 8'hf3},
    '{8'h04, 8'h00, 2'h3, 8'h99}, '{8'h08, 8'h00, 2'h0, 8'h5a}, '{8'h08, 8'h01, 2'h0, 8'h01},
    '{8'h08, 8'h02, 2'h0, 8'h02}, '{8'h08, 8'h03, 2'h0, 8'hff}, '{8'h08, 8'h00, 2'h1, 8'h80},
    '{8'h02, 8'h85, 2'h0, 8'h46}, '{8'h02, 8'h85, 2'h1, 8'ha4}, '{8'h03, 8'h85, 2'h0, 8'h46}};

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Backend: done pulse a fixed time after commit or erase, reads by address
  always @(posedge ref_clk) begin
    nvm_done <= (done_cnt == 5'h01);
    if (nvm_commit === 1'b1 || nvm_erase === 1'b1) done_cnt <= 5'h10;
    else if (done_cnt != 5'h00) done_cnt <= done_cnt - 5'h01;
    if (nvm_erase === 1'b1) ee_seen <= nvm_erase_eeprom;
    if (nvm_commit === 1'b1) page_seen <= nvm_page_addr;
    if (nvm_we === 1'b1) we_cnt <= we_cnt + 1;
    if (nvm_we === 1'b1 && nvm_waddr === 24'h000185) we_data <= nvm_wdata;
  end
  initial nvm_done = 1'b0;
  wire [15:0] nvm_rdata = nvm_rd_addr[15:0] ^ 16'ha5c3;

  pps_prog_model u_prog (.ref_clk(ref_clk), .reset_pin_low(rbl), .vpp_on(vpp),
    .load_strobe_clock(lsc), .page_latch_strobe(pls), .program_strobe_n(psn),
    .output_enable_n(oen), .strobe_action_1(sa1), .strobe_action_0(sa0),
    .byte_select_high(bsh), .byte_select_low(bsl), .data_in(data_in));

  pps_port u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reset_pin_low(rbl), .vpp_on(vpp),
    .load_strobe_clock(lsc), .page_latch_strobe(pls), .program_strobe_n(psn),
    .output_enable_n(oen), .strobe_action_1(sa1), .strobe_action_0(sa0),
    .byte_select_high(bsh), .byte_select_low(bsl), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .ready_busy_n(ready_busy_n), .prog_mode(prog_mode),
    .nvm_done(nvm_done), .nvm_rdata(nvm_rdata), .nvm_rd_addr(nvm_rd_addr),
    .nvm_erase(nvm_erase), .nvm_erase_eeprom(nvm_erase_eeprom), .nvm_we(nvm_we),
    .nvm_is_eeprom(nvm_is_eeprom), .nvm_waddr(nvm_waddr), .nvm_wdata(nvm_wdata),
    .nvm_commit(nvm_commit),
    .nvm_page_addr(nvm_page_addr), .fuse_low(fuse_low), .fuse_high(fuse_high),
    .fuse_ext(fuse_ext), .lock_bits(lock_bits));

  task automatic check(input string what, input logic [23:0] got, input logic [23:0] exp);
    #1;
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_ready();
    for (int i = 0; i < 3000 && ready_busy_n !== 1'b1; i++) @(posedge ref_clk);
    check("ready_busy_n", {23'h0, ready_busy_n}, 24'h1);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #3_000_000;
    mismatches++;
    stop_test();
  end

  initial begin
    rst_n = 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    check("reset_state", {ready_busy_n, prog_mode, data_oe}, 24'h4);
    check("reset_fuses", {fuse_low, fuse_high, fuse_ext}, 24'h5e99f3);
    u_prog.enter(1'b1);
    check("refused_entry", {23'h0, prog_mode}, 24'h0);
    u_prog.leave();
    u_prog.enter(1'b0);
    check("entry", {23'h0, prog_mode}, 24'h1);
    u_prog.load(2'h0, 2'h1, 8'h01);
    foreach (rows[i]) begin
      u_prog.load(2'h2, 2'h0, rows[i].cmd);
      u_prog.load(2'h0, 2'h0, rows[i].al);
      u_prog.read_on(rows[i].bs);
      check("read_data", {16'h0, data_out}, {16'h0, rows[i].exp});
      check("drive_on", {23'h0, data_oe}, 24'h1);
      u_prog.read_off();
      check("drive_off", {23'h0, data_oe}, 24'h0);
    end
    u_prog.load(2'h0, 2'h3, 8'hee);
    u_prog.load(2'h3, 2'h0, 8'h77);
    check("addr_kept", nvm_rd_addr, 24'h000185);
    u_prog.load(2'h0, 2'h2, 8'h02);
    check("addr_ext", nvm_rd_addr, 24'h020185);
    u_prog.load(2'h0, 2'h2, 8'h00);
    for (int s = 0; s < 3; s++) begin
      u_prog.load(2'h2, 2'h0, 8'h40);
      u_prog.load(2'h1, 2'h0, 8'h51 + 8'(s));
      u_prog.write(2'(s));
      wait_ready();
    end
    check("fuse_write", {fuse_low, fuse_high, fuse_ext}, 24'h515253);
    u_prog.load(2'h2, 2'h0, 8'h20);
    u_prog.load(2'h1, 2'h0, 8'hf0);
    u_prog.write(2'h0);
    wait_ready();
    check("lock_write", {16'h0, lock_bits}, 24'h0000f0);
    u_prog.load(2'h2, 2'h0, 8'h80);
    u_prog.write(2'h0);
    check("erase_busy", {23'h0, ready_busy_n}, 24'h0);
    wait_ready();
    check("erase_keep_ee", {23'h0, ee_seen}, 24'h0);
    check("erase_lock", {lock_bits, fuse_low, fuse_high}, 24'hff5152);
    u_prog.load(2'h2, 2'h0, 8'h10);
    u_prog.load(2'h0, 2'h0, 8'h85);
    u_prog.load(2'h1, 2'h0, 8'h34);
    u_prog.load(2'h1, 2'h1, 8'h12);
    u_prog.latch();
    u_prog.load(2'h0, 2'h1, 8'h01);
    u_prog.load(2'h1, 2'h3, 8'hcc);
    for (int k = 0; k < 2; k++) begin
      we_cnt = 0;
      u_prog.write(2'h0);
      check("page_busy", {23'h0, ready_busy_n}, 24'h0);
      wait_ready();
      check("page_words", 24'(we_cnt), 24'd128);
      check("page_word", {8'h0, we_data}, 24'h001234);
      check("page_base", page_seen, 24'h000180);
    end
    u_prog.load(2'h2, 2'h0, 8'h11);
    u_prog.load(2'h1, 2'h0, 8'h5a);
    u_prog.latch();
    we_cnt = 0;
    u_prog.write(2'h0);
    wait_ready();
    check("ee_words", 24'(we_cnt), 24'd8);
    check("ee_word", {8'h0, we_data}, 24'h00125a);
    check("ee_target", {23'h0, nvm_is_eeprom}, 24'h1);
    u_prog.load(2'h2, 2'h0, 8'h00);
    we_cnt = 0;
    u_prog.write(2'h0);
    u_prog.tick(150);
    check("nop_idle", {ready_busy_n, nvm_is_eeprom, 22'(we_cnt)}, 24'h800000);
    stop_test();
  end
endmodule
